/* File: design/ancillary_data_detector.sv */
`timescale 1ns/10ps

module ancillary_data_detector
   import anc_detect_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire vid_mode_t mode,
   input wire logic bus_10bit,
   input wire logic eight_bit,
   input wire words_t video_in,
   input wire filter_set_t [1:0] packet_type_filters,
   input wire logic extraction_stream_select,
   input wire logic extraction_channel_select,
   input wire logic locked,
   input wire logic std_change,
   input wire logic frame_start,
   input wire logic [1:0] status_write,
   input wire logic [1:0] sticky_read,
   output words_t video_out,
   output logic anc_flag_stream_one,
   output logic anc_flag_stream_two,
   output pid_regs_t payload_id,
   output logic [3:0] link_id,
   output logic [1:0] luma_sum_fault,
   output logic [1:0] chroma_sum_fault,
   output logic [1:0] luma_sum_fault_sticky,
   output logic [1:0] chroma_sum_fault_sticky
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      chan_t [NUM_CH-1:0] ch;
      logic flag_one;
      logic flag_two;
      pid_regs_t pid;
      logic [3:0] link_id;
      faults_t flt;
   } state_t;

   state_t s_q;
   state_t s_d;
   chan_t [NUM_CH-1:0] ch_d;
   logic [NUM_CH-1:0] ch_en;
   logic [NUM_CH-1:0] sum_err;
   logic [NUM_CH-1:0] pid_ok;
   logic [NUM_CH-1:0] flag_d;
   logic [1:0] any_prog;

   always_comb begin
      ch_en[0] = 1'b1;
      ch_en[1] = (mode != MODE_SD);
      ch_en[2] = (mode == MODE_3GB);
      ch_en[3] = (mode == MODE_3GB);
   end

   // Filter set in use per channel
   // second filter set
   function automatic logic set_of(input int i, input vid_mode_t m);
      set_of = (m == MODE_3GB) && (i >= 2);
   endfunction : set_of

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         any_prog[k] = 1'b0;
         for (int t = 0; t < NUM_TYPES; t++) begin
            any_prog[k] = any_prog[k] ||
               (packet_type_filters[k][t] != '0);
         end
      end
   end

   // ----------------------------------------------------------------
   // Per channel packet parser
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         logic w_zero;
         logic w_ones;
         logic [9:0] w;
         logic type_hit;
         logic forced;
         logic [9:0] expect_cs;
         filter_set_t fs;

         assign w = video_in[i];
         assign fs = packet_type_filters[set_of(i, mode)];
         assign expect_cs = {~s_q.ch[i].sum[8], s_q.ch[i].sum};

         always_comb begin
            if (eight_bit) begin
               w_zero = (w[9:2] == BYTE_ZERO);
               w_ones = (w[9:2] == BYTE_ONES);
            end else begin
               w_zero = (w == WORD_ZERO);
               w_ones = (w == WORD_ONES);
            end
         end

         always_comb begin
            type_hit = !any_prog[set_of(i, mode)];
            for (int t = 0; t < NUM_TYPES; t++) begin
               if ((fs[t] != '0) &&
                   (fs[t].did == BYTE_ZERO ||
                    fs[t].did == s_q.ch[i].did) &&
                   (fs[t].sdid == BYTE_ZERO ||
                    fs[t].sdid == w[7:0])) begin
                  type_hit = 1'b1;
               end
            end
         end

         // payload id and EDH always kept
         assign forced = (s_q.ch[i].did == DID_EDH) ||
            (s_q.ch[i].did == DID_PAYLOAD && w[7:0] == SDID_PAYLOAD);

         always_comb begin
            ch_d[i] = s_q.ch[i];
            sum_err[i] = 1'b0;
            pid_ok[i] = 1'b0;
            ch_d[i].dly = {s_q.ch[i].dly[DLY_LEN-2:0], w};
            if (s_q.ch[i].frem != '0) begin
               ch_d[i].frem = s_q.ch[i].frem - 9'h001;
            end
            case (s_q.ch[i].st)
               PS_IDLE: begin
                  if (w_zero) begin
                     ch_d[i].st = PS_PRE1;
                  end
               end
               PS_PRE1: begin
                  if (w_ones) begin
                     ch_d[i].st = PS_PRE2;
                  end else if (!w_zero) begin
                     ch_d[i].st = PS_IDLE;
                  end
               end
               PS_PRE2: begin
                  if (w_ones) begin
                     ch_d[i].st = PS_DID;
                  end else if (w_zero) begin
                     ch_d[i].st = PS_PRE1;
                  end else begin
                     ch_d[i].st = PS_IDLE;
                  end
               end
               PS_DID: begin
                  ch_d[i].did = w[7:0];
                  ch_d[i].sum = w[8:0];
                  ch_d[i].st = PS_SDID;
               end
               PS_SDID: begin
                  ch_d[i].sum = s_q.ch[i].sum + w[8:0];
                  ch_d[i].keep = type_hit || forced;
                  ch_d[i].pid = (s_q.ch[i].did == DID_PAYLOAD) &&
                     (w[7:0] == SDID_PAYLOAD);
                  ch_d[i].st = PS_COUNT;
               end
               PS_COUNT: begin
                  ch_d[i].sum = s_q.ch[i].sum + w[8:0];
                  ch_d[i].rem = w[7:0];
                  ch_d[i].idx = '0;
                  ch_d[i].pid = s_q.ch[i].pid &&
                     (w[7:0] == PAYLOAD_COUNT);
                  if (s_q.ch[i].keep) begin
                     ch_d[i].frem = PKT_OVERHEAD + {1'b0, w[7:0]};
                  end
                  if (w[7:0] == BYTE_ZERO) begin
                     ch_d[i].st = PS_SUM;
                  end else begin
                     ch_d[i].st = PS_USER;
                  end
               end
               PS_USER: begin
                  ch_d[i].sum = s_q.ch[i].sum + w[8:0];
                  ch_d[i].rem = s_q.ch[i].rem - 8'h01;
                  ch_d[i].bytes[s_q.ch[i].idx] = w[7:0];
                  if (s_q.ch[i].idx != PID_BYTES_LAST) begin
                     ch_d[i].idx = s_q.ch[i].idx + 2'h1;
                  end
                  if (s_q.ch[i].rem == 8'h01) begin
                     ch_d[i].st = PS_SUM;
                  end
               end
               PS_SUM: begin
                  sum_err[i] = s_q.ch[i].keep && (w != expect_cs);
                  pid_ok[i] = s_q.ch[i].pid && (w == expect_cs);
                  ch_d[i].st = PS_IDLE;
               end
               default: begin
                  ch_d[i].st = PS_IDLE;
               end
            endcase
            // only channels in use are searched
            if (!ch_en[i]) begin
               ch_d[i].st = PS_IDLE;
               ch_d[i].frem = '0;
               sum_err[i] = 1'b0;
               pid_ok[i] = 1'b0;
            end
            flag_d[i] = (ch_d[i].frem != '0);
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Flags, payload registers and fault status
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] y_evt;
      logic [1:0] c_evt;
      logic [1:0] clr;
      s_d = s_q;
      y_evt = '0;
      c_evt = '0;
      clr = '0;
      s_d.ch = ch_d;

      case (mode)
         MODE_SD: begin
            s_d.flag_one = flag_d[0];
            s_d.flag_two = 1'b0;
         end
         MODE_3GB: begin
            if (bus_10bit) begin
               if (extraction_channel_select) begin
                  s_d.flag_one = flag_d[0];
                  s_d.flag_two = flag_d[2];
               end else if (extraction_stream_select) begin
                  s_d.flag_one = flag_d[2];
                  s_d.flag_two = flag_d[3];
               end else begin
                  s_d.flag_one = flag_d[0];
                  s_d.flag_two = flag_d[1];
               end
            end else begin
               s_d.flag_one = flag_d[0] | flag_d[1];
               s_d.flag_two = flag_d[2] | flag_d[3];
            end
         end
         default: begin
            s_d.flag_one = flag_d[0];
            s_d.flag_two = flag_d[1];
         end
      endcase

      // payload bytes, version in byte 1 bit 7
      for (int i = 0; i < NUM_CH; i++) begin
         if (pid_ok[i]) begin
            s_d.pid[2*i] = {ch_d[i].bytes[1], ch_d[i].bytes[0]};
            s_d.pid[2*i+1] = {ch_d[i].bytes[3], ch_d[i].bytes[2]};
         end
      end
      if (pid_ok[0]) begin
         s_d.link_id = ch_d[0].bytes[3][7:4];
      end

      y_evt[0] = sum_err[0];
      c_evt[0] = sum_err[1];
      y_evt[1] = sum_err[2];
      c_evt[1] = sum_err[3];

      // clear sources; a new fault wins
      for (int k = 0; k < 2; k++) begin
         clr[k] = status_write[k] || !locked || std_change ||
            frame_start;
         s_d.flt.luma[k] = y_evt[k] ||
            (s_q.flt.luma[k] && !clr[k]);
         s_d.flt.chroma[k] = c_evt[k] ||
            (s_q.flt.chroma[k] && !clr[k]);
         s_d.flt.luma_sticky[k] = y_evt[k] ||
            (s_q.flt.luma_sticky[k] && !sticky_read[k]);
         s_d.flt.chroma_sticky[k] = c_evt[k] ||
            (s_q.flt.chroma_sticky[k] && !sticky_read[k]);
      end
   end

   // reset clears flags, faults and payload registers
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            s_q.ch[i].st <= PS_IDLE;
         end
         s_q.pid <= {NUM_PID{PID_RESET}};
         s_q.link_id <= LINK_ID_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         video_out[i] = s_q.ch[i].dly[DLY_LEN-1];
      end
   end

   assign anc_flag_stream_one = s_q.flag_one;
   assign anc_flag_stream_two = s_q.flag_two;
   assign payload_id = s_q.pid;
   assign link_id = s_q.link_id;
   assign luma_sum_fault = s_q.flt.luma;
   assign chroma_sum_fault = s_q.flt.chroma;
   assign luma_sum_fault_sticky = s_q.flt.luma_sticky;
   assign chroma_sum_fault_sticky = s_q.flt.chroma_sticky;

endmodule : ancillary_data_detector

/* File: pkg/anc_detect_pkg.sv */
package anc_detect_pkg;

   // ----------------------------------------------------------------
   // Sizes and timing
   // ----------------------------------------------------------------
   localparam int NUM_CH = 4;
   localparam int NUM_TYPES = 5;
   localparam int DLY_LEN = 6;
   localparam int NUM_PID = 8;
   localparam logic [8:0] PKT_OVERHEAD = 9'h007;
   localparam logic [1:0] PID_BYTES_LAST = 2'h3;

   // ----------------------------------------------------------------
   // Packet words
   // ----------------------------------------------------------------
   localparam logic [9:0] WORD_ZERO = 10'h000;
   localparam logic [9:0] WORD_ONES = 10'h3FF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] DID_PAYLOAD = 8'h41;
   localparam logic [7:0] SDID_PAYLOAD = 8'h01;
   localparam logic [7:0] DID_EDH = 8'hF4;
   localparam logic [7:0] PAYLOAD_COUNT = 8'h04;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_PID_BYTES12_DS1 = 12'h828;
   localparam logic [11:0] OFS_PID_BYTES34_DS1 = 12'h829;
   localparam logic [11:0] OFS_PID_ALT_BYTES12_DS1 = 12'h82A;
   localparam logic [11:0] OFS_PID_ALT_BYTES34_DS1 = 12'h82B;
   localparam logic [11:0] OFS_PID_BYTES12_DS2 = 12'h82C;
   localparam logic [11:0] OFS_PID_BYTES34_DS2 = 12'h82D;
   localparam logic [11:0] OFS_PID_ALT_BYTES12_DS2 = 12'h82E;
   localparam logic [11:0] OFS_PID_ALT_BYTES34_DS2 = 12'h82F;
   localparam logic [15:0] PID_RESET = 16'h0000;
   localparam logic [3:0] LINK_ID_RESET = 4'h0;
   // Index of each register pair within the payload id array, and the version bit position
   localparam int PID_BASE_DS1 = 0;
   localparam int PID_ALT_DS1 = 2;
   localparam int PID_BASE_DS2 = 4;
   localparam int PID_ALT_DS2 = 6;
   localparam int PID_VERSION_BIT = 7;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SD = 2'h0,
      MODE_HD = 2'h1,
      MODE_3GA = 2'h2,
      MODE_3GB = 2'h3
   } vid_mode_t;

   typedef enum logic [7:0] {
      PS_IDLE = 8'h01,
      PS_PRE1 = 8'h02,
      PS_PRE2 = 8'h04,
      PS_DID = 8'h08,
      PS_SDID = 8'h10,
      PS_COUNT = 8'h20,
      PS_USER = 8'h40,
      PS_SUM = 8'h80
   } parse_t;

   typedef struct packed {
      logic [7:0] did;
      logic [7:0] sdid;
   } filter_t;

   typedef filter_t [NUM_TYPES-1:0] filter_set_t;
   typedef logic [NUM_CH-1:0][9:0] words_t;
   typedef logic [NUM_PID-1:0][15:0] pid_regs_t;

   typedef struct packed {
      parse_t st;
      logic [7:0] did;
      logic [7:0] rem;
      logic [8:0] sum;
      logic keep;
      logic pid;
      logic [1:0] idx;
      logic [3:0][7:0] bytes;
      logic [8:0] frem;
      logic [DLY_LEN-1:0][9:0] dly;
   } chan_t;

   typedef struct packed {
      logic [1:0] luma;
      logic [1:0] chroma;
      logic [1:0] luma_sticky;
      logic [1:0] chroma_sticky;
   } faults_t;

endpackage : anc_detect_pkg

/* File: verification/anc_detect_chk.sv */
`timescale 1ns/10ps
module anc_detect_chk
   import anc_detect_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire vid_mode_t mode,
   input wire logic locked,
   input wire logic std_change,
   input wire logic frame_start,
   input wire logic [1:0] status_write,
   input wire logic [1:0] sticky_read,
   input wire words_t video_in,
   input wire words_t video_out,
   input wire logic anc_flag_stream_one,
   input wire logic anc_flag_stream_two,
   input wire pid_regs_t payload_id,
   input wire logic [3:0] link_id,
   input wire logic [1:0] luma_sum_fault,
   input wire logic [1:0] luma_sum_fault_sticky,
   input wire logic [1:0] chroma_sum_fault_sticky
);
   // ----------------------------------------------------------------
   // Helpers: age since reset, flag run length, captured data count
   // ----------------------------------------------------------------
   logic [2:0] age_q;
   logic [8:0] run_q;
   logic [7:0] dc_q;
   logic clr0;
   assign clr0 = status_write[0] | ~locked | std_change | frame_start;
   always_ff @(posedge clk) begin
      if (reset) begin
         age_q <= 3'h0;
         run_q <= 9'h000;
         dc_q <= 8'h00;
      end else begin
         age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
         run_q <= anc_flag_stream_one ? run_q + 9'h001 : 9'h000;
         if (anc_flag_stream_one && run_q == 9'h005) begin
            dc_q <= video_out[0][7:0];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   delay_match_a: assert property (age_q == 3'h7 |->
      video_out == $past(video_in, 6)) else $error("video delay wrong");
   sd_one_stream_a: assert property (mode == MODE_SD &&
      $past(mode, 8) == MODE_SD |-> !anc_flag_stream_two)
      else $error("stream two flag in SD");
   flag_preamble_a: assert property ($rose(anc_flag_stream_one) &&
      mode != MODE_3GB |-> video_out[0][9:2] == BYTE_ZERO ##1
      video_out[0][9:2] == BYTE_ONES [*2]) else $error("flag not on preamble");
   flag_length_a: assert property ($fell(anc_flag_stream_one) &&
      mode != MODE_3GB |-> run_q == PKT_OVERHEAD + {1'b0, dc_q})
      else $error("flag length wrong");
   sticky_set_a: assert property ($rose(luma_sum_fault_sticky[0])
      |-> luma_sum_fault[0]) else $error("sticky without live fault");
   live_clear_a: assert property ($fell(luma_sum_fault[0]) |->
      $past(clr0)) else $error("live fault dropped without clear");
   sticky_clear_a: assert property ($fell(luma_sum_fault_sticky[0])
      |-> $past(sticky_read[0])) else $error("sticky dropped unread");
   sticky_two_a: assert property ($fell(chroma_sum_fault_sticky[1])
      |-> $past(sticky_read[1])) else $error("sticky two dropped unread");
   pid_reset_a: assert property ($fell(reset) |->
      payload_id == '0 && link_id == LINK_ID_RESET)
      else $error("payload id not cleared");
   link_id_a: assert property (link_id ==
      payload_id[PID_BASE_DS1+1][15:12]) else $error("link id mismatch");
   cover property ($fell(anc_flag_stream_one));
   cover property ($rose(luma_sum_fault[1]));
   cover property (!$stable(payload_id));
endmodule : anc_detect_chk

bind ancillary_data_detector anc_detect_chk u_chk (.clk, .reset, .mode,
   .locked, .std_change, .frame_start, .status_write, .sticky_read,
   .video_in, .video_out, .anc_flag_stream_one, .anc_flag_stream_two,
   .payload_id, .link_id, .luma_sum_fault, .luma_sum_fault_sticky,
   .chroma_sum_fault_sticky);

/* File: verification/anc_sink.sv */
`timescale 1ns/10ps
module anc_sink
(
   input wire logic clk,
   input wire logic reset,
   input wire logic proc_en,
   input wire logic flag_one,
   input wire logic flag_two,
   output int cnt_one,
   output int cnt_two
);
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_one <= 0;
         cnt_two <= 0;
      end else if (proc_en) begin
         cnt_one <= cnt_one + int'(flag_one);
         cnt_two <= cnt_two + int'(flag_two);
      end
   end
endmodule : anc_sink

/* File: verification/ancillary_data_detector_tb.sv */
`timescale 1ns/10ps
module ancillary_data_detector_tb
   import anc_detect_pkg::*;
;
   typedef struct packed {
      logic [3:0] cfg;
      vid_mode_t md;
      logic [1:0] ch;
      logic [7:0] did;
      logic [7:0] sdid;
      logic bad;
      logic [15:0] flt;
      logic [1:0] keep;
      logic [3:0] ft;
   } row_t;
   logic clk = 1'b0;
   logic reset = 1'b1;
   vid_mode_t mode = MODE_SD;
   logic bus_10bit = 1'b0;
   logic eight_bit = 1'b0;
   words_t video_in = {4{10'h200}};
   filter_set_t [1:0] packet_type_filters = '0;
   logic extraction_stream_select = 1'b0;
   logic extraction_channel_select = 1'b0;
   logic locked = 1'b1;
   logic std_change = 1'b0;
   logic frame_start = 1'b0;
   logic [1:0] status_write = 2'h0;
   logic [1:0] sticky_read = 2'h0;
   logic anc_flag_stream_one;
   logic anc_flag_stream_two;
   pid_regs_t payload_id;
   logic [3:0] link_id;
   logic [1:0] luma_sum_fault;
   logic [1:0] chroma_sum_fault;
   logic [1:0] luma_sum_fault_sticky;
   logic [1:0] chroma_sum_fault_sticky;
   int cnt_one;
   int cnt_two;
   int fails = 0;
   int checked = 0;
   int n1;
   int n2;
   row_t r;
   row_t rows [14] = '{
      '{4'h0, MODE_SD, 2'h0, 8'h50, 8'h01, 1'b1, 16'h0000, 2'h1, 4'h1},
      '{4'h8, MODE_SD, 2'h0, 8'h50, 8'h01, 1'b0, 16'h0000, 2'h1, 4'h0},
      '{4'h0, MODE_HD, 2'h1, 8'h50, 8'h01, 1'b1, 16'h0000, 2'h2, 4'h2},
      '{4'h0, MODE_HD, 2'h0, 8'h60, 8'h77, 1'b1, 16'h6000, 2'h1, 4'h1},
      '{4'h0, MODE_HD, 2'h0, 8'h61, 8'h77, 1'b1, 16'h6000, 2'h0, 4'h0},
      '{4'h0, MODE_HD, 2'h0, 8'h60, 8'h23, 1'b1, 16'h6022, 2'h0, 4'h0},
      '{4'h0, MODE_HD, 2'h0, 8'h60, 8'h22, 1'b1, 16'h6022, 2'h1, 4'h1},
      '{4'h0, MODE_HD, 2'h0, 8'hF4, 8'h00, 1'b0, 16'h6022, 2'h1, 4'h0},
      '{4'h0, MODE_HD, 2'h0, 8'h41, 8'h01, 1'b1, 16'h6022, 2'h1, 4'h1},
      '{4'h0, MODE_3GA, 2'h1, 8'h50, 8'h01, 1'b1, 16'h0000, 2'h2, 4'h2},
      '{4'h0, MODE_3GB, 2'h1, 8'h50, 8'h01, 1'b1, 16'h0000, 2'h1, 4'h2},
      '{4'h0, MODE_3GB, 2'h3, 8'h61, 8'h77, 1'b1, 16'h6022, 2'h2, 4'h8},
      '{4'h5, MODE_3GB, 2'h2, 8'h50, 8'h01, 1'b1, 16'h0000, 2'h2, 4'h4},
      '{4'h6, MODE_3GB, 2'h2, 8'h50, 8'h01, 1'b0, 16'h0000, 2'h1, 4'h0}
   };

   ancillary_data_detector u_dut (.clk, .reset, .mode, .bus_10bit,
      .eight_bit, .video_in, .packet_type_filters,
      .extraction_stream_select, .extraction_channel_select, .locked,
      .std_change, .frame_start, .status_write, .sticky_read,
      .video_out(), .anc_flag_stream_one, .anc_flag_stream_two,
      .payload_id, .link_id, .luma_sum_fault, .chroma_sum_fault,
      .luma_sum_fault_sticky, .chroma_sum_fault_sticky);
   anc_sink u_sink (.clk, .reset, .proc_en(1'b1),
      .flag_one(anc_flag_stream_one), .flag_two(anc_flag_stream_two),
      .cnt_one, .cnt_two);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [127:0] e,
      input logic [127:0] g);
      checked++;
      if (e !== g) begin
         fails++;
         $display("wrong value %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   task automatic send(input logic [1:0] ch, input logic [7:0] did,
      input logic [7:0] sdid, input logic [7:0] dc,
      input logic [31:0] pl, input logic bad);
      logic [8:0] s;
      logic [9:0] w [$];
      s = {1'b0, did} + {1'b0, sdid} + {1'b0, dc};
      w = '{WORD_ZERO, WORD_ONES, WORD_ONES, {2'h0, did}, {2'h0, sdid},
         {2'h0, dc}};
      if (eight_bit) begin
         w[0] = 10'h003;
         w[1] = 10'h3FC;
         w[2] = 10'h3FC;
      end
      for (int i = 0; i < int'(dc); i++) begin
         w.push_back({2'h0, pl[8*i +: 8]});
         s = s + {1'b0, pl[8*i +: 8]};
      end
      w.push_back({~s[8], s} ^ {9'h000, bad});
      foreach (w[i]) begin
         @(negedge clk);
         video_in[ch] = w[i];
      end
      @(negedge clk);
      video_in[ch] = 10'h200;
      repeat (12) @(negedge clk);
   endtask : send

   task automatic pulse(input logic [1:0] sw, input logic [1:0] sr);
      @(negedge clk);
      status_write = sw;
      sticky_read = sr;
      @(negedge clk);
      status_write = 2'h0;
      sticky_read = 2'h0;
   endtask : pulse

   task end_sim;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim();
   end

   initial begin
      repeat (20) @(negedge clk);
      reset = 1'b0;
      foreach (rows[k]) begin
         r = rows[k];
         {eight_bit, bus_10bit, extraction_stream_select,
            extraction_channel_select} = r.cfg;
         mode = r.md;
         packet_type_filters[0][0] = r.flt;
         repeat (10) @(negedge clk);
         n1 = cnt_one;
         n2 = cnt_two;
         send(r.ch, r.did, r.sdid, 8'h03, 32'h04030201, r.bad);
         chk("flag one", r.keep[0] ? 128'hA : 128'h0, cnt_one - n1);
         chk("flag two", r.keep[1] ? 128'hA : 128'h0, cnt_two - n2);
         chk("fault", r.ft, {chroma_sum_fault[1], luma_sum_fault[1],
            chroma_sum_fault[0], luma_sum_fault[0]});
         chk("sticky", r.ft, {chroma_sum_fault_sticky[1],
            luma_sum_fault_sticky[1], chroma_sum_fault_sticky[0],
            luma_sum_fault_sticky[0]});
         pulse(2'h3, 2'h3);
      end
      mode = MODE_HD;
      repeat (10) @(negedge clk);
      send(2'h0, 8'h41, 8'h01, 8'h04, 32'hA4332285, 1'b0);
      chk("pid b12", 16'h2285, payload_id[PID_BASE_DS1]);
      chk("pid b34", 16'hA433, payload_id[PID_BASE_DS1+1]);
      chk("version", 1'b1, payload_id[0][PID_VERSION_BIT]);
      chk("link id", 4'hA, link_id);
      send(2'h0, 8'h41, 8'h01, 8'h04, 32'h11223344, 1'b1);
      chk("pid kept", 16'h2285, payload_id[PID_BASE_DS1]);
      pulse(2'h3, 2'h3);
      mode = MODE_3GB;
      repeat (10) @(negedge clk);
      send(2'h2, 8'h41, 8'h01, 8'h04, 32'h5A6B7C01, 1'b0);
      chk("pid ds2", 16'h7C01, payload_id[PID_BASE_DS2]);
      chk("version", 1'b0, payload_id[4][PID_VERSION_BIT]);
      send(2'h0, 8'h50, 8'h01, 8'h03, 32'h04030201, 1'b1);
      @(negedge clk);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      chk("live clear", 2'h0, luma_sum_fault);
      chk("sticky hold", 2'h1, luma_sum_fault_sticky);
      pulse(2'h0, 2'h1);
      chk("sticky read", 2'h0, luma_sum_fault_sticky);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk("pid reset", 128'h0, payload_id);
      chk("link reset", LINK_ID_RESET, link_id);
      end_sim();
   end
endmodule : ancillary_data_detector_tb
